// ### rtl/i2c_mtx_params.svh
// register map, field positions, mode value and timing constants
`ifndef I2C_MTX_PARAMS_SVH
`define I2C_MTX_PARAMS_SVH

// =====================================================
// register offsets (byte addresses)
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h04
`define OFS_STATUS 8'h08
`define OFS_RELOAD 8'h0C
`define OFS_TXBUF 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18

// =====================================================
// field positions
`define CTRL1_WRITE_COLLISION_FLAG 7
`define CTRL1_EN 5
`define CTRL1_MODE_LO 0
`define CTRL2_ACK_STATUS_FLAG 6
`define CTRL2_STOP 2
`define CTRL2_RESTART 1
`define CTRL2_START 0
`define STATUS_BF 0
`define IRQ_PORT 0
`define IRQ_WRITE_COLLISION_FLAG 1

// =====================================================
// values
`define MODE_RELOAD 4'h8
`define FIXED_DIV 8'h04
`define ZERO32 32'h0000_0000
`define ZERO8 8'h00
`define LAST_BIT 3'h7

`endif

// ### rtl/i2c_mtx_pkg.sv
// types shared by the transmit-path design files
package i2c_mtx_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_START_HOLD, ST_WAIT, ST_BIT_LOW, ST_BIT_HIGH,
        ST_ACK_LOW, ST_ACK_HIGH, ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_DONE,
        ST_RS_LOW, ST_RS_HIGH
    } tx_state_e;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } pin_out_s;

    typedef struct packed {
        logic scl_i;
        logic sda_i;
    } pin_in_s;

    typedef struct packed {
        tx_state_e st;
        logic [7:0] txbuf;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic write_collision_flag;
        logic enable;
        logic [3:0] mode;
        logic start_req;
        logic restart_req;
        logic stop_req;
        logic ack_stat;
        logic bf;
        logic [7:0] reload;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] prdata;
        logic scl_oe;
        logic sda_oe;
        logic sda_want;
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
    } tx_regs_s;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } baud_regs_s;

endpackage

// ### rtl/baud_counter.sv
// reloadable down counter that marks each baud period with a one-cycle tick
`timescale 1ns/1ps
`include "i2c_mtx_params.svh"
module baud_counter #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [W-1:0] reload,
    output logic tick
);
    import i2c_mtx_pkg::*;

    initial begin
        if (W != 8) $error("baud_counter: only W = 8 is supported");
    end

    baud_regs_s r, n;

    // =====================================================
    // counter
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = reload; // suspended: restart a full period on resume
        end else if (r.cnt == `ZERO8) begin
            n.cnt = reload;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tick_period: assert property (
        run && r.cnt == `ZERO8 |=> tick)
        else $error("baud tick missing at rollover");
endmodule // baud_counter

// ### rtl/i2c_master_transmit.sv
// i2c master transmit path with apb register slave
//
// Function
// - writing the transmit buffer starts the baud counter and sends the byte at once.
// - each bit is driven after scl falls, scl stays low one baud period then high one.
// - sda stays stable through scl high and for a hold time after the next fall.
// - buffer full sets on a transmit buffer write and clears after eight bits.
// - on the eighth clock falling edge the master releases sda for the acknowledge.
// - the acknowledge is captured in the ninth clock, clear for ack, set for nack.
// - after the ninth clock the interrupt flag sets, scl stays low, sda released.
// - the address phase sends seven address bits then the direction bit.
// - a buffer write during a byte sets write collision and is discarded.
// - a start request makes a start and raises the interrupt flag when done.
// - after a start the bus is held for a start hold time before anything else.
// - stop or restart requests raise the interrupt flag once complete.
`timescale 1ns/1ps
`include "i2c_mtx_params.svh"
module i2c_master_transmit #(
    parameter int AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire i2c_mtx_pkg::pin_in_s pins_in,
    output i2c_mtx_pkg::pin_out_s pins_out,
    output logic irq
);
    import i2c_mtx_pkg::*;

    initial begin
        if (AW < 8) $error("i2c_master_transmit: AW must be at least 8");
    end

    tx_regs_s r, n;
    logic tick;
    logic baud_run;
    logic [7:0] reload_sel;

    // =====================================================
    // decode helpers
    function automatic logic mapped(input logic [AW-1:0] a);
        case (a[7:0])
            `OFS_CTRL1, `OFS_CTRL2, `OFS_STATUS, `OFS_RELOAD,
            `OFS_TXBUF, `OFS_IRQ_STAT, `OFS_IRQ_MASK: mapped = ((a >> 8) == '0);
            default: mapped = 1'b0;
        endcase
    endfunction

    function automatic logic scl_pulled(input tx_state_e s);
        case (s)
            ST_START_HOLD, ST_WAIT, ST_BIT_LOW, ST_ACK_LOW,
            ST_STOP_LOW, ST_RS_LOW: scl_pulled = 1'b1;
            default: scl_pulled = 1'b0;
        endcase
    endfunction

    function automatic logic sda_pulled(input tx_state_e s, input logic msb);
        case (s)
            ST_START, ST_START_HOLD, ST_STOP_LOW, ST_STOP_HIGH: sda_pulled = 1'b1;
            ST_BIT_LOW, ST_BIT_HIGH: sda_pulled = ~msb;
            default: sda_pulled = 1'b0;
        endcase
    endfunction

    // =====================================================
    // baud generator
    // the fixed divide keeps reload nonzero when reload mode is not chosen
    assign reload_sel = (r.mode == `MODE_RELOAD) ? r.reload : `FIXED_DIV;
    assign baud_run = r.enable && r.st != ST_IDLE && r.st != ST_WAIT;

    baud_counter #(
        .W(8)
    ) u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .run(baud_run),
        .reload(reload_sel),
        .tick(tick)
    );

    // =====================================================
    // next state
    always_comb begin
        logic wr;
        logic idle_ok;
        wr = psel && penable && pwrite;
        idle_ok = r.st == ST_IDLE || r.st == ST_WAIT;
        n = r;
        n.scl_sync = {r.scl_sync[0], pins_in.scl_i};
        n.sda_sync = {r.sda_sync[0], pins_in.sda_i};

        // register reads sampled in the setup phase
        if (psel && !penable) begin
            n.prdata = `ZERO32;
            case (paddr[7:0])
                `OFS_CTRL1: begin
                    n.prdata[`CTRL1_WRITE_COLLISION_FLAG] = r.write_collision_flag;
                    n.prdata[`CTRL1_EN] = r.enable;
                    n.prdata[`CTRL1_MODE_LO +: 4] = r.mode;
                end
                `OFS_CTRL2: begin
                    n.prdata[`CTRL2_ACK_STATUS_FLAG] = r.ack_stat;
                    n.prdata[`CTRL2_STOP] = r.stop_req;
                    n.prdata[`CTRL2_RESTART] = r.restart_req;
                    n.prdata[`CTRL2_START] = r.start_req;
                end
                `OFS_STATUS: n.prdata[`STATUS_BF] = r.bf;
                `OFS_RELOAD: n.prdata[7:0] = r.reload;
                `OFS_TXBUF: n.prdata[7:0] = r.txbuf;
                `OFS_IRQ_STAT: n.prdata[1:0] = r.irq_stat;
                `OFS_IRQ_MASK: n.prdata[1:0] = r.irq_mask;
                default: n.prdata = `ZERO32;
            endcase
            if (!mapped(paddr)) n.prdata = `ZERO32;
        end

        // register writes; hardware sets below override clears
        if (wr && mapped(paddr)) begin
            case (paddr[7:0])
                `OFS_CTRL1: begin
                    n.write_collision_flag = r.write_collision_flag & pwdata[`CTRL1_WRITE_COLLISION_FLAG];
                    n.enable = pwdata[`CTRL1_EN];
                    n.mode = pwdata[`CTRL1_MODE_LO +: 4];
                end
                `OFS_CTRL2: begin
                    n.start_req = r.start_req | pwdata[`CTRL2_START];
                    n.restart_req = r.restart_req | pwdata[`CTRL2_RESTART];
                    n.stop_req = r.stop_req | pwdata[`CTRL2_STOP];
                end
                `OFS_RELOAD: n.reload = pwdata[7:0];
                `OFS_TXBUF: begin
                    if (idle_ok && r.enable) begin
                        n.txbuf = pwdata[7:0];
                        n.shift = pwdata[7:0];
                        n.bit_cnt = 3'h0;
                        n.bf = 1'b1;
                        n.st = ST_BIT_LOW;
                    end else begin
                        n.write_collision_flag = 1'b1;
                        n.irq_stat[`IRQ_WRITE_COLLISION_FLAG] = 1'b1;
                    end
                end
                `OFS_IRQ_STAT: n.irq_stat = r.irq_stat & ~pwdata[1:0];
                `OFS_IRQ_MASK: n.irq_mask = pwdata[1:0];
                default: n.irq_mask = r.irq_mask;
            endcase
            // irq collision bit kept only while already clear and the ctrl1 flag is set; a set bit still clears
            if (paddr[7:0] == `OFS_IRQ_STAT && r.write_collision_flag && !r.irq_stat[`IRQ_WRITE_COLLISION_FLAG]) begin
                n.irq_stat[`IRQ_WRITE_COLLISION_FLAG] = r.irq_stat[`IRQ_WRITE_COLLISION_FLAG];
            end
        end

        // bus sequencer
        case (r.st)
            ST_IDLE: begin
                if (r.start_req && n.st == ST_IDLE) begin
                    n.start_req = 1'b0;
                    n.st = ST_START;
                end
            end
            ST_START: begin
                if (tick) n.st = ST_START_HOLD;
            end
            ST_START_HOLD: begin
                // scl and sda both low a full period before anything else
                if (tick) begin
                    n.st = ST_WAIT;
                    n.irq_stat[`IRQ_PORT] = 1'b1;
                end
            end
            ST_WAIT: begin
                if (n.st == ST_WAIT) begin
                    if (r.stop_req) begin
                        n.stop_req = 1'b0;
                        n.st = ST_STOP_LOW;
                    end else if (r.restart_req) begin
                        n.restart_req = 1'b0;
                        n.st = ST_RS_LOW;
                    end
                end
            end
            ST_BIT_LOW: begin
                if (tick) n.st = ST_BIT_HIGH;
            end
            ST_BIT_HIGH: begin
                if (tick) begin
                    if (r.bit_cnt == `LAST_BIT) begin
                        n.bf = 1'b0;
                        n.st = ST_ACK_LOW;
                    end else begin
                        n.shift = {r.shift[6:0], 1'b0};
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        n.st = ST_BIT_LOW;
                    end
                end
            end
            ST_ACK_LOW: begin
                if (tick) n.st = ST_ACK_HIGH;
            end
            ST_ACK_HIGH: begin
                if (tick) begin
                    n.ack_stat = r.sda_sync[1];
                    n.irq_stat[`IRQ_PORT] = 1'b1;
                    n.st = ST_WAIT;
                end
            end
            ST_STOP_LOW: begin
                if (tick) n.st = ST_STOP_HIGH;
            end
            ST_STOP_HIGH: begin
                if (tick) n.st = ST_STOP_DONE;
            end
            ST_STOP_DONE: begin
                // sda released with scl high: the stop itself, then a bus free time
                if (tick) begin
                    n.irq_stat[`IRQ_PORT] = 1'b1;
                    n.st = ST_IDLE;
                end
            end
            ST_RS_LOW: begin
                if (tick) n.st = ST_RS_HIGH;
            end
            ST_RS_HIGH: begin
                if (tick) n.st = ST_START; // restart ends like a start
            end
            default: n.st = ST_IDLE;
        endcase

        if (!n.enable) begin
            n.st = ST_IDLE;
            n.start_req = 1'b0;
            n.restart_req = 1'b0;
            n.stop_req = 1'b0;
            n.bf = 1'b0;
        end

        // scl moves first, sda follows one cycle later for hold time
        n.scl_oe = scl_pulled(n.st);
        n.sda_want = sda_pulled(n.st, n.shift[7]);
        n.sda_oe = r.sda_want;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // =====================================================
    // outputs
    assign prdata = r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign irq = |(r.irq_stat & r.irq_mask);
    assign pins_out.scl_o = 1'b0;
    assign pins_out.sda_o = 1'b0;
    assign pins_out.scl_oe = r.scl_oe;
    assign pins_out.sda_oe = r.sda_oe;

    // =====================================================
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_write_launch: assert property (
        psel && penable && pwrite && paddr[7:0] == `OFS_TXBUF && r.enable
        && (r.st == ST_IDLE || r.st == ST_WAIT) |=> r.st == ST_BIT_LOW && r.bf)
        else $error("buffer write did not launch a byte");

    a_scl_low_high: assert property (
        r.st == ST_BIT_LOW && tick |=> r.st == ST_BIT_HIGH ##1 !pins_out.scl_oe)
        else $error("scl not released after low period");

    a_sda_stable: assert property (
        r.st == ST_BIT_HIGH && $past(r.st) == ST_BIT_HIGH |-> $stable(pins_out.sda_oe))
        else $error("sda moved while scl high");

    a_bf_clear: assert property (
        r.st == ST_BIT_HIGH && tick && r.bit_cnt == `LAST_BIT |=> !r.bf)
        else $error("buffer full not cleared after eighth bit");

    a_sda_release: assert property (
        r.st == ST_ACK_LOW && $past(r.st) == ST_ACK_LOW |-> !pins_out.sda_oe)
        else $error("sda not released for acknowledge");

    a_ack_capture: assert property (
        r.st == ST_ACK_HIGH && tick |=> r.ack_stat == $past(r.sda_sync[1]))
        else $error("acknowledge status wrong");

    a_ninth_hold: assert property (
        r.st == ST_ACK_HIGH && tick && r.enable
        |=> r.irq_stat[`IRQ_PORT] && r.st == ST_WAIT ##1 pins_out.scl_oe && !baud_run)
        else $error("ninth clock did not set flag and hold scl");

    a_write_collision_flag_set: assert property (
        psel && penable && pwrite && paddr[7:0] == `OFS_TXBUF && !(r.st == ST_IDLE
        || r.st == ST_WAIT) |=> r.write_collision_flag && $stable(r.txbuf))
        else $error("collision not flagged or buffer changed");

    a_start_hold: assert property (
        r.st == ST_START_HOLD && tick |=> r.irq_stat[`IRQ_PORT] || !r.enable)
        else $error("start completion flag missing");

    a_stop_flag: assert property (
        r.st == ST_STOP_DONE && tick && r.enable |=> r.irq_stat[`IRQ_PORT] && r.st == ST_IDLE)
        else $error("stop completion flag missing");

    a_hold_both_low: assert property (
        r.st == ST_START_HOLD && $past(r.st) == ST_START_HOLD
        |-> pins_out.scl_oe && pins_out.sda_oe)
        else $error("start hold did not keep both lines low");

    a_start_shape: assert property (
        r.st == ST_START && $past(r.st) == ST_START |-> pins_out.sda_oe && !pins_out.scl_oe)
        else $error("start condition lines wrong");

    a_wait_suspend: assert property (
        r.st == ST_WAIT && $past(r.st) == ST_WAIT
        |-> pins_out.scl_oe && !pins_out.sda_oe && !tick)
        else $error("wait state did not hold scl low with counter stopped");

    a_stop_release: assert property (
        r.st == ST_STOP_DONE && $past(r.st) == ST_STOP_DONE
        |-> !pins_out.scl_oe && !pins_out.sda_oe)
        else $error("stop did not release both lines");

    a_restart_release: assert property (
        r.st == ST_RS_LOW && $past(r.st) == ST_RS_LOW |-> pins_out.scl_oe && !pins_out.sda_oe)
        else $error("restart did not release sda under low scl");

endmodule // i2c_master_transmit

// ### verif/i2c_slave_model.sv
// behavioural i2c slave that follows the bus and answers the ack bit
`timescale 1ns/1ps
module i2c_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_data,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic stop_seen
);
    logic [7:0] sh = 8'h00;
    logic first = 1'b0;
    int bits = -1;
    initial begin
        sda_oe = 1'b0;
        rx_byte = 8'h00;
        stop_seen = 1'b0;
    end
    // =======
    // framing: start and stop are sda edges while scl is high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bits = 0;
            first = 1'b1;
            stop_seen = 1'b0;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            bits = -1;
            stop_seen = 1'b1;
        end
    end
    // =======
    // bits taken on scl rising, msb first; count 9 marks the ack clock
    always @(posedge scl) begin
        if (bits == 8) bits = 9;
        else if (bits >= 0) begin
            sh = {sh[6:0], sda};
            bits = bits + 1;
            if (bits == 8) rx_byte = sh;
        end
    end
    // ack held from the 8th fall to the 9th fall, else the pull-up wins
    always @(negedge scl) begin
        if (bits == 8) sda_oe = first ? (sh[7:1] == ADDR) : !nack_data;
        else if (bits == 9) begin
            sda_oe = 1'b0;
            bits = 0;
            first = 1'b0;
        end
    end
endmodule // i2c_slave_model

// ### verif/tb.sv
// self-checking bench for the i2c master transmit path
`timescale 1ns/1ps
`include "i2c_mtx_params.svh"
module tb;
    import i2c_mtx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, seed, c1;
    pin_in_s pins_in;
    pin_out_s pins_out;
    logic slv_oe, nack_data, stop_seen, in_byte, e, ack_q;
    logic [7:0] rx_byte;
    int err_total, checked, per;
    int hcnt = 0;
    int hi_len = 0;
    int lcnt = 0;
    int hold_len = 0;
    localparam logic [6:0] SLV = 7'h2a;
    // open drain lines with pull-ups
    wire scl = !pins_out.scl_oe;
    wire sda = !(pins_out.sda_oe || slv_oe);
    assign pins_in = {scl, sda};

    i2c_master_transmit #(.AW(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));
    i2c_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda), .nack_data(nack_data),
        .sda_oe(slv_oe), .rx_byte(rx_byte), .stop_seen(stop_seen));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // =======
    // line timing monitors: scl high runs, and sda low under scl high
    always @(posedge pclk) begin
        if (scl === 1'b1) hcnt <= hcnt + 1;
        else begin
            if (hcnt != 0) hi_len <= hcnt;
            hcnt <= 0;
        end
        if (scl === 1'b1 && sda === 1'b0) lcnt <= lcnt + 1;
        else begin
            if (lcnt != 0) hold_len <= lcnt;
            lcnt <= 0;
        end
    end
    always @(sda) begin
        if (in_byte === 1'b1 && scl === 1'b1) chk(32'h0000_0000, 32'h0000_0001);
    end
    // =======
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic tally_and_finish();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        err_total++;
        tally_and_finish();
    endtask
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) timeout();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge pclk);
        #1;
        chk(irq, v);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 4000; n++) begin
            @(posedge pclk);
            if (irq === 1'b1) break;
        end
        if (n == 4000) timeout();
    endtask
    task automatic cond(input logic [31:0] cmd);
        wr(`OFS_CTRL2, cmd);
        wait_irq();
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
        rd(`OFS_CTRL2, {25'h000_0000, ack_q, 6'h00});
    endtask
    task automatic send(input logic [7:0] v, input logic ack, input logic coll);
        in_byte = 1'b1;
        wr(`OFS_TXBUF, {24'h00_0000, v});
        rd(`OFS_STATUS, 32'h0000_0001);
        if (coll) begin
            wr(`OFS_TXBUF, {24'h00_0000, ~v});
            rd(`OFS_CTRL1, c1 | 32'h0000_0080);
            rd(`OFS_TXBUF, {24'h00_0000, v});
            rd(`OFS_IRQ_STAT, 32'h0000_0002);
        end
        wait_irq();
        in_byte = 1'b0;
        chk({pins_out.scl_oe, pins_out.sda_oe}, 2'b10);
        chk(rx_byte, v);
        chk(hi_len >= per && hi_len <= per + 1, 1'b1);
        rd(`OFS_CTRL2, {25'h000_0000, ack, 6'h00});
        ack_q = ack;
        rd(`OFS_STATUS, 32'h0000_0000);
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
    endtask
    // =======
    // main sequence
    initial begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        nack_data = 1'b0;
        ack_q = 1'b0;
        in_byte = 1'b0;
        seed = 32'h0000_002a;
        err_total = 0;
        checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (n = 0; n <= 24; n += 4) rd(n[7:0], 32'h0000_0000);
        apb(1'b0, 8'h1c, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        chk(q, 32'h0000_0000);
        seed = xs(seed);
        per = (seed % 3) + 2;
        // reload kept nonzero in reload mode
        wr(`OFS_RELOAD, per - 1);
        c1 = 32'h0000_0028;
        wr(`OFS_CTRL1, c1);
        wr(`OFS_CTRL2, 32'h0000_0001);
        q = 32'h0000_0000;
        for (n = 0; n < 200 && q[0] !== 1'b1; n++) apb(1'b0, `OFS_IRQ_STAT, 32'h0000_0000);
        if (n == 200) timeout();
        chk(irq, 1'b0);
        chk(hold_len >= per && hold_len <= per + 1, 1'b1);
        chk(pins_out.scl_oe, 1'b1);
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        irq_is(1'b1);
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
        irq_is(1'b0);
        send({SLV, 1'b0}, 1'b0, 1'b1);
        rd(`OFS_CTRL1, c1 | 32'h0000_0080);
        wr(`OFS_IRQ_MASK, 32'h0000_0003);
        irq_is(1'b1);
        wr(`OFS_CTRL1, c1);
        wr(`OFS_IRQ_STAT, 32'h0000_0002);
        irq_is(1'b0);
        rd(`OFS_CTRL1, c1);
        for (n = 0; n < 6; n++) begin
            seed = xs(seed);
            nack_data = seed[8];
            send(seed[7:0], seed[8], 1'b0);
        end
        cond(32'h0000_0004);
        chk({scl, sda, stop_seen}, 3'b111);
        c1 = 32'h0000_0020;
        per = 5;
        wr(`OFS_CTRL1, c1);
        cond(32'h0000_0001);
        send({~SLV, 1'b1}, 1'b1, 1'b0);
        cond(32'h0000_0002);
        // a restart start runs on a live counter and sda lags scl by one cycle
        chk(hold_len, per - 1);
        send({SLV, 1'b0}, 1'b0, 1'b0);
        cond(32'h0000_0004);
        chk({scl, sda, stop_seen}, 3'b111);
        tally_and_finish();
    end
endmodule // tb
